// >>> verilog/ssrb_regs.svh
// Register offsets, field positions and preset values of the status bank
`ifndef SSRB_REGS_SVH
`define SSRB_REGS_SVH
// ----------------------------------------
// Per-register sections, register i at i * stride
// ----------------------------------------
`define SSRB_NUM_REGS 5
`define SSRB_REG_STRIDE 8'h20
`define SSRB_SEC_COND 5'h00
`define SSRB_SEC_EVENT 5'h04
`define SSRB_SEC_ENABLE 5'h08
`define SSRB_SEC_RISE 5'h0c
`define SSRB_SEC_FALL 5'h10
// ----------------------------------------
// Bank-wide registers
// ----------------------------------------
`define SSRB_CTRL 8'ha0
`define SSRB_FORMAT 8'ha4
`define SSRB_ERRQ 8'ha8
`define SSRB_TEXT 8'hac
`define SSRB_IRQ_STAT 8'hb0
`define SSRB_IRQ_MASK 8'hb4
`define SSRB_SUMMARY 8'hb8
// ----------------------------------------
// Fields
// ----------------------------------------
`define SSRB_CTRL_PRESET 0
`define SSRB_CTRL_INSTRST 1
`define SSRB_ERRQ_NOERR 16
`define SSRB_TEXT_VALID 8
`define SSRB_IRQ_OVF 5
`define SSRB_IRQ_W 6
// ----------------------------------------
// Preset and reset values, and the fixed text lengths of the hex and binary formats
// ----------------------------------------
`define SSRB_PRESET_RISE 16'hffff
`define SSRB_PRESET_FALL 16'h0000
`define SSRB_PRESET_ENA_LO 16'h0000
`define SSRB_PRESET_ENA_HI 16'hffff
`define SSRB_HEX_LEN 5'h06
`define SSRB_BIN_LEN 5'h12
`endif

// >>> verilog/ssrb_pkg.sv
// Types shared by the status bank and its text formatter
package ssrb_pkg;
   typedef enum logic [1:0] {
      SSRB_FMT_DEC = 2'h0,
      SSRB_FMT_BIN = 2'h1,
      SSRB_FMT_HEX = 2'h2
   } ssrb_fmt_t;
   typedef enum logic [1:0] {
      SSRB_ST_IDLE = 2'b01,
      SSRB_ST_EMIT = 2'b10
   } ssrb_state_t;
endpackage

// >>> verilog/ssrb_fmt_if.sv
// Carrier between the bank and the ASCII formatter
interface ssrb_fmt_if;
   logic load;
   logic [15:0] value;
   ssrb_pkg::ssrb_fmt_t mode;
   logic pop;
   logic [7:0] chr;
   logic valid;
   modport bank (output load, output value, output mode, output pop, input chr, input valid);
   modport fmt (input load, input value, input mode, input pop, output chr, output valid);
endinterface

// >>> verilog/ssrb_fmt.sv
// Turns a 16-bit register value into ASCII characters, one per pop
`include "ssrb_regs.svh"
module ssrb_fmt (
   input wire logic mclk,
   input wire logic resetn,
   ssrb_fmt_if.fmt f
);
   logic [15:0] val_r;
   ssrb_pkg::ssrb_fmt_t mode_r;
   ssrb_pkg::ssrb_state_t state_r;
   logic [4:0] pos_r;
   logic [4:0] len_r;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Decimal suppresses leading zeros, so length depends on value
   function automatic logic [4:0] text_len(input ssrb_pkg::ssrb_fmt_t m, input logic [15:0] v);
      if (m == ssrb_pkg::SSRB_FMT_HEX) return `SSRB_HEX_LEN;
      else if (m == ssrb_pkg::SSRB_FMT_BIN) return `SSRB_BIN_LEN;
      else if (v >= 16'd10000) return 5'd5;
      else if (v >= 16'd1000) return 5'd4;
      else if (v >= 16'd100) return 5'd3;
      else if (v >= 16'd10) return 5'd2;
      else return 5'd1;
   endfunction

   function automatic logic [7:0] hex_chr(input logic [3:0] n);
      return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction

   function automatic logic [7:0] char_at(input ssrb_pkg::ssrb_fmt_t m, input logic [15:0] v,
                                          input logic [4:0] p, input logic [4:0] l);
      logic [4:0] k;
      logic [15:0] q;
      k = l - p - 5'd1;
      q = v;
      if (m != ssrb_pkg::SSRB_FMT_DEC && p == 5'd0) return 8'h23;
      else if (m == ssrb_pkg::SSRB_FMT_HEX) begin
         if (p == 5'd1) return 8'h48;
         return hex_chr(v[4'(k) * 4 +: 4]);
      end else if (m == ssrb_pkg::SSRB_FMT_BIN) begin
         if (p == 5'd1) return 8'h42;
         return v[4'(k)] ? 8'h31 : 8'h30;
      end
      // Constant divisors keep this a fixed combinational divide
      case (k)
         5'd0: q = v % 16'd10;
         5'd1: q = (v / 16'd10) % 16'd10;
         5'd2: q = (v / 16'd100) % 16'd10;
         5'd3: q = (v / 16'd1000) % 16'd10;
         default: q = v / 16'd10000;
      endcase
      return 8'h30 + q[7:0];
   endfunction

   // ----------------------------------------
   // Emit sequence; a new load restarts it
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ssrb_pkg::SSRB_ST_IDLE;
         val_r <= 16'h0000;
         mode_r <= ssrb_pkg::SSRB_FMT_DEC;
         pos_r <= 5'h00;
         len_r <= 5'h00;
      end else if (f.load) begin
         state_r <= ssrb_pkg::SSRB_ST_EMIT;
         val_r <= f.value;
         mode_r <= f.mode;
         pos_r <= 5'h00;
         len_r <= text_len(f.mode, f.value);
      end else begin
         case (state_r)
            ssrb_pkg::SSRB_ST_EMIT: begin
               if (f.pop) begin
                  pos_r <= pos_r + 5'd1;
                  if (pos_r + 5'd1 == len_r) state_r <= ssrb_pkg::SSRB_ST_IDLE;
               end
            end
            default: state_r <= ssrb_pkg::SSRB_ST_IDLE;
         endcase
      end
   end

   assign f.valid = (state_r == ssrb_pkg::SSRB_ST_EMIT);
   assign f.chr = f.valid ? char_at(mode_r, val_r, pos_r, len_r) : 8'h00;
endmodule

// >>> verilog/ssrb_bank.sv
// Status register bank with APB access, transition filters and error queue
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`include "ssrb_regs.svh"
module ssrb_bank #(
   parameter int ERR_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0][15:0] cond_in,
   input wire logic err_push,
   input wire logic [15:0] err_code,
   output logic [4:0] summary,
   output logic irq
);
   localparam int PW = $clog2(ERR_DEPTH);
   localparam int NR = `SSRB_NUM_REGS;

   // Four stored sections per register plus the edge detector history
   logic [15:0] prev_r [NR];
   logic [15:0] event_r [NR];
   logic [15:0] enable_r [NR];
   logic [15:0] rise_r [NR];
   logic [15:0] fall_r [NR];
   logic [15:0] set_ev [NR];
   // Read path and bank-wide settings
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   ssrb_pkg::ssrb_fmt_t format_r;
   logic [4:0] summary_r;
   logic [`SSRB_IRQ_W-1:0] stat_r;
   logic [`SSRB_IRQ_W-1:0] mask_r;
   logic [`SSRB_IRQ_W-1:0] stat_set;
   // Error queue storage and slot indices
   logic [15:0] err_mem [ERR_DEPTH];
   logic [PW-1:0] wr_slot_r;
   logic [PW-1:0] rd_slot_r;
   logic [PW:0] count_r;
   // Bus decode and one-cycle strobes
   logic setup;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic preset;
   logic inst_rst;
   logic err_pop;
   logic err_wr;
   logic [2:0] a_idx;
   logic [4:0] a_sec;
   logic a_bank;

   // Carrier to the text formatter
   ssrb_fmt_if fif ();

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   // Queue slots wrap at the depth, which need not be a power of two
   function automatic logic [PW-1:0] slot_next(input logic [PW-1:0] p);
      if (p == PW'(ERR_DEPTH - 1)) return '0;
      else return p + 1'b1;
   endfunction

   // Enable preset: registers 0 and 1 start masked, the rest open
   function automatic logic [15:0] preset_ena(input int i);
      if (i < 2) return `SSRB_PRESET_ENA_LO;
      else return `SSRB_PRESET_ENA_HI;
   endfunction

   // ----------------------------------------
   // Address decoding
   // ----------------------------------------
   // Section decode: register index in the top bits, section below
   function automatic logic is_sec(input logic [7:0] a);
      logic [4:0] s;
      s = a[4:0];
      if (a >= `SSRB_CTRL) return 1'b0;
      else if (s == `SSRB_SEC_COND || s == `SSRB_SEC_EVENT) return 1'b1;
      else if (s == `SSRB_SEC_ENABLE || s == `SSRB_SEC_RISE) return 1'b1;
      else if (s == `SSRB_SEC_FALL) return 1'b1;
      else return 1'b0;
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      if (is_sec(a)) return 1'b1;
      else if (a == `SSRB_CTRL || a == `SSRB_FORMAT || a == `SSRB_ERRQ) return 1'b1;
      else if (a == `SSRB_TEXT || a == `SSRB_IRQ_STAT) return 1'b1;
      else if (a == `SSRB_IRQ_MASK || a == `SSRB_SUMMARY) return 1'b1;
      else return 1'b0;
   endfunction

   assign a_idx = paddr[7:5];
   assign a_sec = paddr[4:0];
   assign a_bank = is_sec(paddr);
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_acc = access & pwrite;
   assign rd_acc = access & ~pwrite;

   // ----------------------------------------
   // APB answer
   // ----------------------------------------
   // Zero wait states; read data is latched in the setup cycle so side
   // effects in the access cycle cannot disturb what is returned
   assign pready = 1'b1;
   assign pslverr = access & ~addr_ok(paddr);
   assign prdata = prdata_r;

   // Read multiplexer, evaluated during setup
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (a_bank) begin
         if (a_sec == `SSRB_SEC_COND) rd_nxt[15:0] = cond_in[a_idx];
         else if (a_sec == `SSRB_SEC_EVENT) rd_nxt[15:0] = event_r[a_idx];
         else if (a_sec == `SSRB_SEC_ENABLE) rd_nxt[15:0] = enable_r[a_idx];
         else if (a_sec == `SSRB_SEC_RISE) rd_nxt[15:0] = rise_r[a_idx];
         else rd_nxt[15:0] = fall_r[a_idx];
      end else if (paddr == `SSRB_FORMAT) begin
         rd_nxt[1:0] = format_r;
      end else if (paddr == `SSRB_ERRQ) begin
         // Empty queue answers code zero with the no-error flag
         if (count_r == '0) rd_nxt[`SSRB_ERRQ_NOERR] = 1'b1;
         else rd_nxt[15:0] = err_mem[rd_slot_r];
      end else if (paddr == `SSRB_TEXT) begin
         rd_nxt[`SSRB_TEXT_VALID:0] = {fif.valid, fif.chr};
      end else if (paddr == `SSRB_IRQ_STAT) begin
         rd_nxt[`SSRB_IRQ_W-1:0] = stat_r;
      end else if (paddr == `SSRB_IRQ_MASK) begin
         rd_nxt[`SSRB_IRQ_W-1:0] = mask_r;
      end else if (paddr == `SSRB_SUMMARY) begin
         rd_nxt[4:0] = summary_r;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) prdata_r <= 32'h0000_0000;
      else if (setup && !pwrite) prdata_r <= rd_nxt;
   end

   // ----------------------------------------
   // Control strobes
   // ----------------------------------------
   // Both act only for the write cycle; nothing of them is stored
   assign preset = wr_acc && paddr == `SSRB_CTRL && pwdata[`SSRB_CTRL_PRESET];
   assign inst_rst = wr_acc && paddr == `SSRB_CTRL && pwdata[`SSRB_CTRL_INSTRST];

   // Number format; undefined codes are ignored
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         format_r <= ssrb_pkg::SSRB_FMT_DEC;
      end else if (inst_rst) begin
         format_r <= ssrb_pkg::SSRB_FMT_DEC;
      end else if (wr_acc && paddr == `SSRB_FORMAT && pwdata[1:0] != 2'h3) begin
         format_r <= ssrb_pkg::ssrb_fmt_t'(pwdata[1:0]);
      end
   end

   // ----------------------------------------
   // Status registers
   // ----------------------------------------
   // Transition detection against last sampled condition
   always_comb begin
      for (int i = 0; i < NR; i++) begin
         set_ev[i] = (cond_in[i] & ~prev_r[i] & rise_r[i])
                   | (~cond_in[i] & prev_r[i] & fall_r[i]);
      end
   end

   // History has no reset, so levels standing high at release are not taken
   // for rising edges; it needs one clock edge inside reset to settle
   always_ff @(posedge mclk) begin
      for (int i = 0; i < NR; i++) prev_r[i] <= cond_in[i];
   end

   // Events: only bits actually returned are cleared, new edges win
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NR; i++) begin
            event_r[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < NR; i++) begin
            if (rd_acc && a_bank && a_sec == `SSRB_SEC_EVENT && a_idx == 3'(i)) begin
               event_r[i] <= (event_r[i] & ~prdata_r[15:0]) | set_ev[i];
            end else begin
               event_r[i] <= event_r[i] | set_ev[i];
            end
         end
      end
   end

   // Enables and filters; instrument reset has no path in here
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NR; i++) begin
            enable_r[i] <= preset_ena(i);
            rise_r[i] <= `SSRB_PRESET_RISE;
            fall_r[i] <= `SSRB_PRESET_FALL;
         end
      end else if (preset) begin
         for (int i = 0; i < NR; i++) begin
            // Operation and questionable start masked, the rest open
            enable_r[i] <= preset_ena(i);
            rise_r[i] <= `SSRB_PRESET_RISE;
            fall_r[i] <= `SSRB_PRESET_FALL;
         end
      end else if (wr_acc && a_bank) begin
         if (a_sec == `SSRB_SEC_ENABLE) enable_r[a_idx] <= pwdata[15:0];
         else if (a_sec == `SSRB_SEC_RISE) rise_r[a_idx] <= pwdata[15:0];
         else if (a_sec == `SSRB_SEC_FALL) fall_r[a_idx] <= pwdata[15:0];
      end
   end

   // Summary lags the event section by one cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         summary_r <= 5'h00;
      end else begin
         for (int i = 0; i < NR; i++) summary_r[i] <= |(event_r[i] & enable_r[i]);
      end
   end
   assign summary = summary_r;

   // ----------------------------------------
   // Error queue
   // ----------------------------------------
   // A full queue drops the newest entry and flags the overflow
   assign err_pop = rd_acc && paddr == `SSRB_ERRQ && count_r != '0;
   assign err_wr = err_push && (count_r != (PW + 1)'(ERR_DEPTH) || err_pop);

   always_ff @(posedge mclk) begin
      if (err_wr) err_mem[wr_slot_r] <= err_code;
   end

   // Push and pop in one cycle both act, so the count then stands still
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_slot_r <= '0;
         rd_slot_r <= '0;
         count_r <= '0;
      end else begin
         if (err_wr) wr_slot_r <= slot_next(wr_slot_r);
         if (err_pop) rd_slot_r <= slot_next(rd_slot_r);
         if (err_wr && !err_pop) count_r <= count_r + 1'b1;
         else if (err_pop && !err_wr) count_r <= count_r - 1'b1;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   // Bits 4..0 flag new enabled events per register, bit 5 a lost error
   always_comb begin
      stat_set = '0;
      for (int i = 0; i < NR; i++) stat_set[i] = |(set_ev[i] & enable_r[i]);
      stat_set[`SSRB_IRQ_OVF] = err_push & ~err_wr;
   end

   // Write one to clear; a set in the same cycle is kept
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stat_r <= '0;
         mask_r <= '0;
      end else begin
         if (wr_acc && paddr == `SSRB_IRQ_STAT) begin
            stat_r <= (stat_r & ~pwdata[`SSRB_IRQ_W-1:0]) | stat_set;
         end else begin
            stat_r <= stat_r | stat_set;
         end
         if (wr_acc && paddr == `SSRB_IRQ_MASK) mask_r <= pwdata[`SSRB_IRQ_W-1:0];
      end
   end
   assign irq = |(stat_r & mask_r);

   // ----------------------------------------
   // ASCII rendering of section reads
   // ----------------------------------------
   // Only the latest section read can be fetched as text
   assign fif.load = rd_acc & a_bank;
   assign fif.value = prdata_r[15:0];
   assign fif.mode = format_r;
   assign fif.pop = rd_acc && paddr == `SSRB_TEXT && fif.valid;

   ssrb_fmt u_fmt (
      .mclk(mclk),
      .resetn(resetn),
      .f(fif.fmt)
   );
endmodule

// >>> verif/ssrb_bank_asserts.sv
// Port-level checks on the status register bank
`include "ssrb_regs.svh"
module ssrb_bank_asserts #(
   parameter int ERR_DEPTH = 8
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [4:0][15:0] cond_in,
   input wire logic err_push,
   input wire logic [15:0] err_code,
   input wire logic [4:0] summary,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0][15:0] cond_q;
   logic [3:0] stab_cnt;
   logic acc;
   logic rd;
   logic sec;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Access-phase decode
   assign acc = psel && penable;
   assign rd = acc && !pwrite;
   assign sec = paddr < `SSRB_CTRL;
   // Condition copy taken at the edge where the bank latches read data
   always_ff @(posedge mclk) begin
      cond_q <= cond_in;
   end
   // Steady-condition count; held at zero in reset to stay on the safe side
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stab_cnt <= 4'h0;
      end else if (cond_in != cond_q) begin
         stab_cnt <= 4'h0;
      end else if (stab_cnt != 4'hf) begin
         stab_cnt <= stab_cnt + 4'h1;
      end
   end
   function automatic logic mapped(input logic [7:0] a);
      if (a < `SSRB_CTRL) begin
         return a[4:0] inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
      end
      return a <= `SSRB_SUMMARY && a[1:0] == 2'h0;
   endfunction
   chk_map_error: assert property (acc |-> pready && pslverr == !mapped(paddr))
      else $error("bad ready or error in access phase");
   chk_cond_live: assert property (
      rd && sec && paddr[4:0] == `SSRB_SEC_COND |-> prdata == {16'h0, cond_q[paddr[7:5]]})
      else $error("condition read not live");
   chk_upper_zero: assert property (rd && sec |-> prdata[31:16] == 16'h0)
      else $error("section read upper half not zero");
   chk_ctrl_zero: assert property (rd && paddr == `SSRB_CTRL |-> prdata == 32'h0)
      else $error("preset control read not zero");
   chk_noerr_code: assert property (
      rd && paddr == `SSRB_ERRQ && prdata[`SSRB_ERRQ_NOERR] |-> prdata[15:0] == 16'h0)
      else $error("empty queue code not zero");
   chk_event_clear: assert property (
      rd && sec && paddr[4:0] == `SSRB_SEC_EVENT && stab_cnt > 4'h5 && $past(rd, 2)
      && $past(paddr, 2) == paddr |-> (prdata[15:0] & $past(prdata[15:0], 2)) == 16'h0)
      else $error("event bits not cleared by read");
   chk_summary_quiet: assert property (
      !psel && $past(!psel) && stab_cnt > 4'h3 |=> $stable(summary))
      else $error("summary moved without cause");
   chk_irq_release: assert property ($fell(irq) |-> $past(acc && pwrite))
      else $error("irq fell without a write");
   cover property (rd && paddr == `SSRB_TEXT && prdata[`SSRB_TEXT_VALID]);
   cover property ($rose(irq));
   cover property (acc && pslverr);
endmodule
bind ssrb_bank ssrb_bank_asserts #(.ERR_DEPTH(ERR_DEPTH)) chk_u (.mclk(mclk),
   .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cond_in(cond_in), .err_push(err_push), .err_code(err_code), .summary(summary),
   .irq(irq));

// >>> verif/ssrb_apb_host.sv
// APB master standing in for the remote controller
module ssrb_apb_host (
   input wire logic mclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer; keep leaves psel up so the next setup follows at once
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic keep, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      penable <= 1'b0;
      // Idle bus shows inverted values so stale data cannot pass
      if (!keep) begin
         psel <= 1'b0;
         paddr <= ~a;
         pwdata <= ~d;
         @(posedge mclk);
      end
   endtask
endmodule

// >>> verif/test_ssrb_bank.sv
// Self-checking bench for the status register bank
`include "ssrb_regs.svh"
module test_ssrb_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err_push, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [4:0][15:0] cond_in;
   logic [15:0] err_code;
   logic [4:0] summary;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   string fmt_txt[3] = '{"300", "#B0000000100101100", "#H012C"};
   ssrb_apb_host host_u (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ssrb_bank #(.ERR_DEPTH(4)) dut_u (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cond_in(cond_in), .err_push(err_push),
      .err_code(err_code), .summary(summary), .irq(irq));
   always #12.5 mclk = ~mclk;
   // Hang guard, well above the full sequence length
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         stop_test();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   function automatic logic [7:0] sa(input int i, input logic [4:0] x);
      return 8'(i) * `SSRB_REG_STRIDE + {3'h0, x};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      host_u.xfer(1'b1, a, d, 1'b0, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      host_u.xfer(1'b0, a, 32'h0, 1'b0, q, e);
      cmp(q, x);
   endtask
   task automatic check_defaults();
      for (int i = 0; i < 5; i++) begin
         rdc(sa(i, `SSRB_SEC_ENABLE), i < 2 ? 32'h0 : 32'hffff);
         rdc(sa(i, `SSRB_SEC_RISE), 32'hffff);
         rdc(sa(i, `SSRB_SEC_FALL), 32'h0);
      end
   endtask
   task automatic check_written();
      for (int i = 0; i < 5; i++) begin
         rdc(sa(i, `SSRB_SEC_ENABLE), 32'h1230 + i);
         rdc(sa(i, `SSRB_SEC_RISE), 32'hfa50 + i);
         rdc(sa(i, `SSRB_SEC_FALL), 32'h0f0 + i);
      end
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      logic [31:0] q;
      logic e;
      mclk = 1'b0;
      resetn = 1'b0;
      cond_in = '0;
      err_push = 1'b0;
      err_code = 16'h0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      check_defaults();
      $display("test reset finished");
      // Values stay in 16 bits, as the controller must keep them
      for (int i = 0; i < 5; i++) begin
         wr(sa(i, `SSRB_SEC_ENABLE), 32'h1230 + i);
         wr(sa(i, `SSRB_SEC_RISE), 32'hfa50 + i);
         wr(sa(i, `SSRB_SEC_FALL), 32'h0f0 + i);
      end
      check_written();
      wr(`SSRB_FORMAT, 32'h2);
      wr(`SSRB_FORMAT, 32'h3);
      rdc(`SSRB_FORMAT, 32'h2);
      wr(`SSRB_CTRL, 32'h2);
      check_written();
      rdc(`SSRB_FORMAT, 32'h0);
      wr(`SSRB_CTRL, 32'h1);
      check_defaults();
      rdc(`SSRB_CTRL, 32'h0);
      $display("test sections finished");
      cond_in[1] <= 16'h0008;
      cond_in[2] <= 16'hc001;
      @(posedge mclk);
      rdc(sa(1, `SSRB_SEC_COND), 32'h0008);
      rdc(sa(2, `SSRB_SEC_COND), 32'hc001);
      wr(sa(2, `SSRB_SEC_COND), 32'hffff);
      rdc(sa(2, `SSRB_SEC_COND), 32'hc001);
      rdc(sa(2, `SSRB_SEC_EVENT), 32'hc001);
      wr(`SSRB_IRQ_STAT, 32'h3f);
      wr(`SSRB_IRQ_MASK, 32'h08);
      wr(sa(3, `SSRB_SEC_RISE), 32'h1);
      wr(sa(3, `SSRB_SEC_FALL), 32'h2);
      cmp({31'h0, irq}, 32'h0);
      cond_in[3] <= 16'h0003;
      repeat (4) @(posedge mclk);
      cmp({27'h0, summary}, 32'h08);
      cmp({31'h0, irq}, 32'h1);
      host_u.xfer(1'b0, sa(3, `SSRB_SEC_EVENT), 32'h0, 1'b1, q, e);
      cmp(q, 32'h1);
      host_u.xfer(1'b0, sa(3, `SSRB_SEC_EVENT), 32'h0, 1'b0, q, e);
      cmp(q, 32'h0);
      repeat (2) @(posedge mclk);
      cmp({27'h0, summary}, 32'h0);
      cond_in[3] <= 16'h0000;
      repeat (4) @(posedge mclk);
      rdc(sa(3, `SSRB_SEC_EVENT), 32'h2);
      wr(`SSRB_IRQ_STAT, 32'h08);
      cmp({31'h0, irq}, 32'h0);
      wr(`SSRB_IRQ_MASK, 32'h0);
      cond_in[3] <= 16'h0003;
      repeat (4) @(posedge mclk);
      cmp({31'h0, irq}, 32'h0);
      rdc(`SSRB_IRQ_STAT, 32'h08);
      $display("test events finished");
      rdc(`SSRB_ERRQ, 32'h10000);
      // Five pushes into four places: the last is dropped
      for (int k = 0; k < 5; k++) begin
         err_push <= 1'b1;
         err_code <= 16'h0a0 + 16'(k);
         @(posedge mclk);
         err_push <= 1'b0;
         @(posedge mclk);
      end
      rdc(`SSRB_IRQ_STAT, 32'h28);
      for (int k = 0; k < 4; k++) rdc(`SSRB_ERRQ, 32'h0a0 + k);
      rdc(`SSRB_ERRQ, 32'h10000);
      $display("test queue finished");
      wr(sa(1, `SSRB_SEC_ENABLE), 32'd300);
      for (int f = 0; f < 3; f++) begin
         wr(`SSRB_FORMAT, 32'(f));
         rdc(sa(1, `SSRB_SEC_ENABLE), 32'd300);
         for (int k = 0; k < fmt_txt[f].len(); k++) begin
            host_u.xfer(1'b0, `SSRB_TEXT, 32'h0, 1'b0, q, e);
            cmp(q & 32'h1ff, {23'h0, 1'b1, fmt_txt[f][k]});
         end
         host_u.xfer(1'b0, `SSRB_TEXT, 32'h0, 1'b0, q, e);
         cmp(q & 32'h100, 32'h0);
      end
      $display("test text finished");
      host_u.xfer(1'b0, 8'h14, 32'h0, 1'b0, q, e);
      cmp({31'h0, e}, 32'h1);
      cmp(q, 32'h0);
      host_u.xfer(1'b1, 8'hbc, 32'h5, 1'b0, q, e);
      cmp({31'h0, e}, 32'h1);
      $display("test map finished");
      stop_test();
   end
endmodule
